// ### core/uoesc_cfg.svh
/*
  Offsets, field positions, reset values and widths of the OUT endpoint
  status and control block. Assumes a 32-bit Avalon-MM slave port with
  one byte-wide register per aligned word (byte address = index * 4).
*/
// Operation
// - ISO mode: CRC or bit-stuff faulted packet sets data error; packet-ready clear drops it.
// - ISO mode: packet lost to a full FIFO sets overrun; firmware clears it.
// - FIFO full reads 1 at two packets when double buffered, else one.
// - Packet ready sets while a packet waits; firmware clears it after unloading.
// - Control high bit 7 enables double buffering; read/write, resets to 0.
// - Control high bit 6 selects isochronous (1) or bulk/interrupt (0); resets 0.
// - Control high bits 5:0 read as zero and ignore writes.
// - Writing 1 to flush drops the next packet, clears packet ready unless a second packet waits, self-clears.
// - Read-only 10-bit count of the head packet, valid while packet ready is 1.
`ifndef UOESC_CFG_SVH
`define UOESC_CFG_SVH

`define UOESC_IDX_CTRL_LO   6'h14
`define UOESC_IDX_CTRL_HI   6'h15
`define UOESC_IDX_CNT_LO    6'h16
`define UOESC_IDX_CNT_HI    6'h17
`define UOESC_IDX_IRQ_STAT  6'h18
`define UOESC_IDX_IRQ_MASK  6'h19

`define UOESC_LO_PKT_RDY    0
`define UOESC_LO_FIFO_FULL  1
`define UOESC_LO_OVERRUN    2
`define UOESC_LO_DATA_ERR   3
`define UOESC_LO_FLUSH      4
`define UOESC_HI_ISO        6
`define UOESC_HI_DBL        7

`define UOESC_IRQ_PKT       0
`define UOESC_IRQ_OVR       1
`define UOESC_IRQ_ERR       2

`define UOESC_RST_BYTE      8'h00
`define UOESC_RST_IRQ       3'h0
`define UOESC_LEN_W         10
`define UOESC_QUEUE_DEPTH   2

`endif

// ### core/uoesc_pkg.sv
/*
  Types shared by the OUT endpoint status and control block.
  Assumes uoesc_cfg.svh is available on the include path.
*/
`include "uoesc_cfg.svh"

package uoesc_pkg;

  typedef logic [`UOESC_LEN_W-1:0] uoesc_len_type;

  typedef enum logic [0:0] {
    UOESC_FLUSH_IDLE = 1'b0,
    UOESC_FLUSH_RUN  = 1'b1
  } uoesc_flush_type;

endpackage

// ### core/uoesc_q_if.sv
/*
  Interface between the register front end and the packet queue.
  Assumes both ends share one clock; every signal is same-cycle.
*/
`timescale 1ns/10ps

interface uoesc_q_if;
  logic                  push;
  uoesc_pkg::uoesc_len_type push_len;
  logic                  pop;
  logic                  dbl;
  logic [1:0]            count;
  logic                  full;
  uoesc_pkg::uoesc_len_type head_len;

  modport mgr   (output push, push_len, pop, dbl,
                 input  count, full, head_len);
  modport queue (input  push, push_len, pop, dbl,
                 output count, full, head_len);
endinterface

// ### core/uoesc_pkt_queue.sv
/*
  Two-entry queue of received packet descriptors (byte count only).
  Assumes the front end never pushes while full nor pops while empty.
*/
`timescale 1ns/10ps
`include "uoesc_cfg.svh"

module uoesc_pkt_queue (
  input wire logic i_clk,  // Controller clock.
  input wire logic i_rst,  // Synchronous reset, active high.
  uoesc_q_if.queue q       // Push, pop and occupancy.
);

  uoesc_pkg::uoesc_len_type len_mem_q [`UOESC_QUEUE_DEPTH];
  logic                     wr_ptr_q;
  logic                     rd_ptr_q;
  logic [1:0]               count_q;
  logic [1:0]               count_d;
  logic [1:0]               cap;

  // ---------------------------------------------------------------------
  // Occupancy
  // ---------------------------------------------------------------------
  assign cap      = q.dbl ? 2'h2 : 2'h1;
  assign count_d  = count_q + {1'b0, q.push} - {1'b0, q.pop};
  assign q.count  = count_q;
  // Full is judged against the live mode, so turning double buffering off
  // with two packets held still reports full until they drain.
  assign q.full   = (count_q >= cap);
  assign q.head_len = len_mem_q[rd_ptr_q];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      count_q <= count_d;
      if (q.push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (q.pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      len_mem_q[0] <= '0;
      len_mem_q[1] <= '0;
    end else if (q.push) begin
      len_mem_q[wr_ptr_q] <= q.push_len;
    end
  end

endmodule // uoesc_pkt_queue

// ### core/uoesc_top.sv
/*
  Status and control of the selected USB OUT endpoint, with its register
  window on an Avalon-MM slave port. Assumes the receive engine runs on the
  same clock and presents each finished OUT packet as a one-cycle strobe
  with its byte count and a CRC or bit-stuff fault flag. Packet bytes live
  in the endpoint FIFO elsewhere; this block tracks packets only.
*/
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/10ps
`include "uoesc_cfg.svh"

module uoesc_top (
  input  wire logic        i_clk,             // Controller clock, 100 MHz.
  input  wire logic        i_rst,             // Synchronous reset, active high.
  input  wire logic [7:0]  i_avs_address,     // Byte address.
  input  wire logic        i_avs_read,        // Read request.
  input  wire logic        i_avs_write,       // Write request.
  input  wire logic [31:0] i_avs_writedata,   // Write data.
  input  wire logic [3:0]  i_avs_byteenable,  // Byte lanes.
  output logic      [31:0] o_avs_readdata,    // Read data, registered.
  output logic             o_avs_waitrequest, // Stall of the current request.
  input  wire logic        i_rx_valid,        // One-cycle end of an OUT packet.
  input  wire logic [9:0]  i_rx_len,          // Byte count of that packet.
  input  wire logic        i_rx_crc_err,      // CRC or bit-stuff fault seen.
  output logic             o_rx_accept,       // Packet was kept, registered.
  output logic             o_fifo_full,       // Endpoint cannot take a packet.
  output logic             o_pkt_ready,       // A packet waits for firmware.
  output logic             o_irq              // Level interrupt, registered.
);

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  function automatic logic reg_hit(input logic [5:0] idx,
                                   input logic [5:0] reg_idx);
    reg_hit = (idx == reg_idx);
  endfunction

  wire [5:0] idx       = i_avs_address[7:2];
  wire       lane0     = i_avs_byteenable[0];
  wire       hit_lo    = reg_hit(idx, `UOESC_IDX_CTRL_LO);
  wire       hit_hi    = reg_hit(idx, `UOESC_IDX_CTRL_HI);
  wire       hit_cntl  = reg_hit(idx, `UOESC_IDX_CNT_LO);
  wire       hit_cnth  = reg_hit(idx, `UOESC_IDX_CNT_HI);
  wire       hit_stat  = reg_hit(idx, `UOESC_IDX_IRQ_STAT);
  wire       hit_mask  = reg_hit(idx, `UOESC_IDX_IRQ_MASK);

  // Writes complete in the cycle they appear; only lane 0 carries data.
  wire       wr_lo     = i_avs_write & lane0 & hit_lo;
  wire       wr_hi     = i_avs_write & lane0 & hit_hi;
  wire       wr_stat   = i_avs_write & lane0 & hit_stat;
  wire       wr_mask   = i_avs_write & lane0 & hit_mask;
  wire [7:0] wbyte     = i_avs_writedata[7:0];

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  uoesc_q_if qif ();

  logic                    dbl_q;
  logic                    iso_q;
  logic                    overrun_q;
  logic                    overrun_d;
  logic                    data_err_q;
  logic                    data_err_d;
  uoesc_pkg::uoesc_flush_type flush_q;
  uoesc_pkg::uoesc_flush_type flush_d;
  logic [2:0]              irq_stat_q;
  logic [2:0]              irq_stat_d;
  logic [2:0]              irq_mask_q;
  logic                    irq_q;
  logic                    rd_done_q;
  logic [31:0]             rdata_q;
  logic                    accept_q;

  uoesc_pkt_queue u_queue (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .q     (qif.queue)
  );

  // ---------------------------------------------------------------------
  // Receive side
  // ---------------------------------------------------------------------
  wire pkt_ready  = (qif.count != 2'h0);
  // Outside ISO mode a faulted packet is never kept; the host will retry.
  wire rx_drop    = i_rx_valid & i_rx_crc_err & ~iso_q;
  wire rx_store   = i_rx_valid & ~qif.full & ~rx_drop;
  wire rx_overrun = i_rx_valid & qif.full & iso_q;
  wire err_set    = rx_store & i_rx_crc_err & iso_q;

  // ---------------------------------------------------------------------
  // Firmware side
  // ---------------------------------------------------------------------
  // A flush request takes over the packet-ready clear in the same write,
  // so one write never drops two packets.
  wire flush_req   = wr_lo & wbyte[`UOESC_LO_FLUSH];
  wire fw_clr_rdy  = wr_lo & ~wbyte[`UOESC_LO_PKT_RDY] & ~flush_req
                     & pkt_ready;
  wire flush_run   = (flush_q == uoesc_pkg::UOESC_FLUSH_RUN);
  wire flush_pop   = flush_run & pkt_ready;
  wire pop         = fw_clr_rdy | flush_pop;
  wire ovr_clr     = wr_lo & ~wbyte[`UOESC_LO_OVERRUN];

  assign qif.push     = rx_store;
  assign qif.push_len = i_rx_len;
  assign qif.pop      = pop;
  assign qif.dbl      = dbl_q;

  // ---------------------------------------------------------------------
  // Flush sequencer
  // ---------------------------------------------------------------------
  // The flush bit reads 1 for the single cycle in which the head packet is
  // dropped, then falls back by itself.
  always_comb begin
    case (flush_q)
      uoesc_pkg::UOESC_FLUSH_IDLE: begin
        flush_d = flush_req ? uoesc_pkg::UOESC_FLUSH_RUN
                            : uoesc_pkg::UOESC_FLUSH_IDLE;
      end
      uoesc_pkg::UOESC_FLUSH_RUN: begin
        flush_d = uoesc_pkg::UOESC_FLUSH_IDLE;
      end
      default: begin
        flush_d = uoesc_pkg::UOESC_FLUSH_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Flags: a set in the same cycle as its clear wins
  // ---------------------------------------------------------------------
  assign overrun_d  = rx_overrun | (overrun_q & ~ovr_clr);
  assign data_err_d = err_set | (data_err_q & ~pop);
  assign irq_stat_d = {err_set, rx_overrun, rx_store}
                      | (irq_stat_q & ~({3{wr_stat}} & wbyte[2:0]));

  // ---------------------------------------------------------------------
  // Configuration and flag registers
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dbl_q <= 1'b0;
      iso_q <= 1'b0;
    end else if (wr_hi) begin
      dbl_q <= wbyte[`UOESC_HI_DBL];
      iso_q <= wbyte[`UOESC_HI_ISO];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      overrun_q  <= 1'b0;
      data_err_q <= 1'b0;
      flush_q    <= uoesc_pkg::UOESC_FLUSH_IDLE;
      accept_q   <= 1'b0;
    end else begin
      overrun_q  <= overrun_d;
      data_err_q <= data_err_d;
      flush_q    <= flush_d;
      accept_q   <= rx_store;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat_q <= `UOESC_RST_IRQ;
      irq_mask_q <= `UOESC_RST_IRQ;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_mask) begin
        irq_mask_q <= wbyte[2:0];
      end
      irq_q <= |(irq_stat_d & (wr_mask ? wbyte[2:0] : irq_mask_q));
    end
  end

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  // The count is only meaningful while a packet waits, so it reads zero
  // otherwise rather than a stale length.
  wire [9:0] cnt_val = pkt_ready ? qif.head_len : 10'h000;

  wire [7:0] lo_byte = {3'h0,
                        flush_run,
                        data_err_q,
                        overrun_q,
                        qif.full,
                        pkt_ready};
  wire [7:0] hi_byte = {dbl_q, iso_q, 6'h00};

  wire [7:0] rd_mux  = hit_lo   ? lo_byte :
                       hit_hi   ? hi_byte :
                       hit_cntl ? cnt_val[7:0] :
                       hit_cnth ? {6'h00, cnt_val[9:8]} :
                       hit_stat ? {5'h00, irq_stat_q} :
                       hit_mask ? {5'h00, irq_mask_q} :
                                  8'h00;

  // Reads take one wait cycle so that read data come from a flip-flop.
  wire rd_take = i_avs_read & ~rd_done_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_done_q <= 1'b0;
      rdata_q   <= 32'h00000000;
    end else begin
      rd_done_q <= rd_take;
      if (rd_take) begin
        rdata_q <= {24'h000000, rd_mux};
      end
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = rd_take;
  assign o_rx_accept       = accept_q;
  assign o_fifo_full       = qif.full;
  assign o_pkt_ready       = pkt_ready;
  assign o_irq             = irq_q;

endmodule // uoesc_top

// ### testbench/uoesc_host_model.sv
/*
  Behavioural USB host side: turns a one-cycle send request into the
  receive engine's end-of-packet strobe with byte count and fault flag.
  Assumes the bench raises i_send for one cycle just after a clock edge.
*/
`timescale 1ns/10ps

module uoesc_host_model (
  input  wire logic       i_clk,        // Controller clock.
  input  wire logic       i_send,       // Send one OUT packet.
  input  wire logic [9:0] i_len,        // Its byte count.
  input  wire logic       i_err,        // Corrupt it with a CRC fault.
  output logic            o_rx_valid,   // End-of-packet strobe.
  output logic      [9:0] o_rx_len,     // Byte count with the strobe.
  output logic            o_rx_crc_err  // Fault with the strobe.
);
  // Outside the strobe the count and fault toggle, so a design that
  // samples them late cannot pass by luck.
  always_ff @(posedge i_clk) begin
    o_rx_valid   <= i_send;
    o_rx_len     <= i_send ? i_len : ~o_rx_len;
    o_rx_crc_err <= i_send ? i_err : ~o_rx_crc_err;
  end
endmodule // uoesc_host_model

// ### testbench/uoesc_top_checker.sv
/*
  Concurrent checks on the ports of the OUT endpoint block.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps

module uoesc_top_checker (
  input wire logic        i_clk,             // Clock.
  input wire logic        i_rst,             // Reset.
  input wire logic        i_avs_read,        // Read request.
  input wire logic        i_avs_write,       // Write request.
  input wire logic [31:0] o_avs_readdata,    // Read data.
  input wire logic        o_avs_waitrequest, // Stall.
  input wire logic        i_rx_valid,        // Packet strobe.
  input wire logic        i_rx_crc_err,      // Packet fault.
  input wire logic        o_rx_accept,       // Packet kept.
  input wire logic        o_fifo_full,       // Full flag.
  input wire logic        o_pkt_ready        // Ready flag.
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_wr; i_avs_write |-> !o_avs_waitrequest; endproperty
  a_wr: assert property (p_wr) else $error("write was stalled");
  property p_rd1; $rose(i_avs_read) |-> o_avs_waitrequest; endproperty
  a_rd1: assert property (p_rd1) else $error("read answered without a wait");
  property p_rd2; o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_rd2: assert property (p_rd2) else $error("read stalled more than one cycle");
  property p_hi; o_avs_readdata[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("upper read data not zero");
  property p_acc; i_rx_valid && !o_fifo_full && !i_rx_crc_err |=> o_rx_accept; endproperty
  a_acc: assert property (p_acc) else $error("good packet not stored");
  property p_nacc; i_rx_valid && o_fifo_full |=> !o_rx_accept; endproperty
  a_nacc: assert property (p_nacc) else $error("packet stored while full");
  property p_rise; $rose(o_pkt_ready) |-> o_rx_accept; endproperty
  a_rise: assert property (p_rise) else $error("ready rose with no packet");
  property p_full; o_fifo_full |-> o_pkt_ready; endproperty
  a_full: assert property (p_full) else $error("full while empty");
endmodule // uoesc_top_checker

bind uoesc_top uoesc_top_checker u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_rx_valid(i_rx_valid), .i_rx_crc_err(i_rx_crc_err),
  .o_rx_accept(o_rx_accept), .o_fifo_full(o_fifo_full), .o_pkt_ready(o_pkt_ready));

// ### testbench/usb_out_endpoint_status_ctrl_bench.sv
/*
  Self-checking bench for the OUT endpoint block: Avalon-MM register
  tasks, a host model for packets, and flag comparisons.
  Assumes the bound checker and the host model are compiled first.
*/
`timescale 1ns/10ps

module usb_out_endpoint_status_ctrl_bench;
  logic        clk, rst, rd, wr, send, err, wait_r, vld, cerr, acc, full, rdy, irq;
  logic [7:0]  adr;
  logic [31:0] wd, rdat, q;
  logic [3:0]  be;
  logic [9:0]  len, rlen;
  int          n_fail, n_checks;

  uoesc_top DUT (.i_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_r), .i_rx_valid(vld), .i_rx_len(rlen), .i_rx_crc_err(cerr),
    .o_rx_accept(acc), .o_fifo_full(full), .o_pkt_ready(rdy), .o_irq(irq));
  uoesc_host_model u_host (.i_clk(clk), .i_send(send), .i_len(len), .i_err(err),
    .o_rx_valid(vld), .o_rx_len(rlen), .o_rx_crc_err(cerr));

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // Request is held until a rising edge samples waitrequest low; read data
  // are taken at that same edge, and only then is the request released.
  task automatic xfer(input logic r, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    rd  <= r;
    wr  <= !r;
    wd  <= d;
    be  <= b;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    if (wait_r !== 1'b0) begin
      $display("unexpected waitrequest expected 0 seen %b", wait_r);
      n_fail++;
      report_and_stop();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b0, a, {24'h000000, d}, 4'hF);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b1, a, 32'h00000000, 4'hF);
    chk("register", {24'h000000, e}, q);
  endtask

  task automatic pkt(input logic [9:0] l, input logic e);
    @(posedge clk);
    send <= 1'b1;
    len  <= l;
    err  <= e;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Flags are compared mid-cycle, one edge after the last event.
  task automatic flags(input logic [2:0] e);
    @(posedge clk);
    @(negedge clk);
    chk("irq_full_ready", {29'h0, e}, {29'h0, irq, full, rdy});
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_fail   = 0;
    n_checks = 0;
    rst      = 1'b1;
    rd       = 1'b0;
    wr       = 1'b0;
    adr      = 8'h00;
    wd       = 32'h00000000;
    be       = 4'hF;
    send     = 1'b0;
    len      = 10'h000;
    err      = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rreg(8'h54, 8'h00);
    rreg(8'h50, 8'h00);
    wreg(8'h54, 8'hFF);
    rreg(8'h54, 8'hC0);
    xfer(1'b0, 8'h54, 32'h00000000, 4'hE);
    rreg(8'h54, 8'hC0);
    wreg(8'h54, 8'h00);
    rreg(8'h54, 8'h00);
    rreg(8'h7C, 8'h00);
    $display("test registers done");
    pkt(10'h155, 1'b1);
    flags(3'b000);
    pkt(10'h2A5, 1'b0);
    flags(3'b011);
    rreg(8'h58, 8'hA5);
    rreg(8'h5C, 8'h02);
    pkt(10'h001, 1'b0);
    rreg(8'h50, 8'h03);
    rreg(8'h58, 8'hA5);
    wreg(8'h50, 8'h00);
    flags(3'b000);
    $display("test bulk single done");
    wreg(8'h54, 8'h80);
    rreg(8'h54, 8'h80);
    pkt(10'h011, 1'b0);
    flags(3'b001);
    pkt(10'h022, 1'b0);
    flags(3'b011);
    wreg(8'h50, 8'h10);
    repeat (3) @(posedge clk);
    flags(3'b001);
    rreg(8'h50, 8'h01);
    rreg(8'h58, 8'h22);
    wreg(8'h50, 8'h00);
    flags(3'b000);
    $display("test double flush done");
    wreg(8'h54, 8'h40);
    rreg(8'h54, 8'h40);
    pkt(10'h010, 1'b1);
    rreg(8'h50, 8'h0B);
    pkt(10'h020, 1'b0);
    rreg(8'h50, 8'h0F);
    rreg(8'h58, 8'h10);
    wreg(8'h50, 8'h01);
    rreg(8'h50, 8'h0B);
    flags(3'b011);
    wreg(8'h64, 8'h07);
    flags(3'b111);
    rreg(8'h60, 8'h07);
    wreg(8'h60, 8'h07);
    flags(3'b011);
    rreg(8'h60, 8'h00);
    wreg(8'h50, 8'h00);
    rreg(8'h50, 8'h00);
    $display("test iso irq done");
    report_and_stop();
  end
endmodule // usb_out_endpoint_status_ctrl_bench
